// File: iop_ports.sv
// Purpose: Five GPIO ports, Port 3 input functions and the reset pin
// Assumes: Analog comparator and IR amplifier results arrive as levels
// Notes:   Function
// Function
// - Five 8-bit ports; Port 0 nibble, Port 1 byte, Ports 2/4 bit direction.
// - Port 3 has four inputs low and four outputs high.
// - Pull-ups of Ports 0,1,2,4 are off on pins set to output.
// - Reads return pin levels, except the Port 3 output bits, so read-modify-write uses pins.
// - Open-drain one floats the pin and reads whatever pulls it.
// - Power-on, watchdog, stop recovery, low voltage or pin reset initialise.
// - Power-on or watchdog drives reset pin low, pull-up off meanwhile.
// - Reset pin is not driven low from the clock after brown-out is first seen.
// - External reset pin does not end stop mode.
// - Port 0 drive mode from config bit 2; input after reset or recovery.
// - UART transmit takes Port 0 pin 7 when its enable bit is set; the pin drives it when upper nibble is output.
// - Port 1 shares one drive mode; pull-ups follow flash option.
// - Power-on makes Port 1 and Port 2 all inputs.
// - Port 2 OR, AND and edge logic; pin 0 to edge logic in demod.
// - Programming pin sampled as each power-on or watchdog reset drive ends; low selects open-drain mode.
// - Port 3 outputs 5-7 push/pull, may carry timer or comparator outputs.
// - Port 3 input 1 to IR amp or comparator; IR amp wins.
// - In analog mode Port 3 bit 0 reads as one.
// - In analog mode inputs 1 and 2 are not stop recovery sources.
// - Input 1 function drives interrupt 2 on chosen edge and timer edge.
// - Input 2 is UART receive, comparator two, or interrupt 0.
// - Config bit 0 routes comparator or IR outputs to Port 3 pins 4 and 7.
//
// Our own choice: the APB slave port.
`timescale 1ns/100ps
module iop_ports #(
   parameter int unsigned POR_CYCLES = iop_pkg::POR_CYC
) (
   // Clock, reset, enable
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              clk_en,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [13:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Port pins
   input  wire logic [7:0]        p0_in,
   input  wire logic [7:0]        p1_in,
   input  wire logic [7:0]        p2_in,
   input  wire logic [3:0]        p3_in,
   input  wire logic [7:0]        p4_in,
   input  wire logic              prog_pin_in,
   output iop_pkg::iop_pin_s      p0_pin,
   output iop_pkg::iop_pin_s      p1_pin,
   output iop_pkg::iop_pin_s      p2_pin,
   output iop_pkg::iop_pin_s      p3_pin,
   output iop_pkg::iop_pin_s      p4_pin,
   // Reset pin
   input  wire logic              rst_pin_in,
   output logic                   rst_pin_out,
   output logic                   rst_pin_oe,
   output logic                   rst_pin_pu,
   // System and peripheral inputs
   input  wire logic              wdt_timeout,
   input  wire logic              low_voltage,
   input  wire logic              stop_recovery,
   input  wire logic              stop_mode,
   input  wire logic              brownout,
   input  wire logic              demod_mode,
   input  wire logic [4:0]        pullup_opt,
   input  wire logic              uart_txd,
   input  wire logic [1:0]        tmr_out,
   // Analog results
   input  wire logic              cmp1_out,
   input  wire logic              cmp2_out,
   input  wire logic              ir_amp_out,
   // Status and events
   output logic                   device_reset,
   output logic                   icp_mode,
   output logic                   interrupt_request_2_req,
   output logic                   interrupt_request_0_req,
   output logic                   uart_rxd,
   output logic                   tmr_edge_p31,
   output logic                   tmr_edge_p20,
   output logic                   stop_wake,
   output logic                   p2_or,
   output logic                   p2_and
);
   localparam int SW = 41;
   localparam int CW = $clog2(POR_CYCLES + 1);

   // ==========================================================
   // Input synchronisers
   logic [SW-1:0] async_in;
   logic [SW-1:0] s1_reg;
   logic [SW-1:0] s2_reg;
   logic [SW-1:0] s3_reg;
   logic [SW-1:0] flt_reg;
   logic [SW-1:0] agree;

   assign async_in = {prog_pin_in, ir_amp_out, cmp2_out, cmp1_out,
                      rst_pin_in, p3_in, p4_in, p2_in, p1_in, p0_in};
   assign agree    = s2_reg ~^ s3_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_reg  <= '1;
         s2_reg  <= '1;
         s3_reg  <= '1;
         flt_reg <= '1;
      end
      else if (clk_en)
      begin
         s1_reg  <= async_in;
         s2_reg  <= s1_reg;
         s3_reg  <= s2_reg;
         flt_reg <= (agree & s2_reg) | (~agree & flt_reg);
      end
   end

   logic [7:0] p0_lvl, p1_lvl, p2_lvl, p4_lvl;
   logic [3:0] p3_lvl;
   logic       rst_lvl, cmp1_lvl, cmp2_lvl, ir_lvl, prog_lvl;
   assign p0_lvl   = flt_reg[7:0];
   assign p1_lvl   = flt_reg[15:8];
   assign p2_lvl   = flt_reg[23:16];
   assign p4_lvl   = flt_reg[31:24];
   assign p3_lvl   = flt_reg[35:32];
   assign rst_lvl  = flt_reg[36];
   assign cmp1_lvl = flt_reg[37];
   assign cmp2_lvl = flt_reg[38];
   assign ir_lvl   = flt_reg[39];
   assign prog_lvl = flt_reg[40];

   // ==========================================================
   // Reset sequencing
   iop_pkg::iop_rst_e rst_state;
   logic [CW-1:0]     por_cnt;
   logic              rst_hi_seen;
   logic              ext_rst;
   logic              soft_rst_reg;
   logic              smr_rst_reg;
   logic              driving;

   assign driving = (rst_state == iop_pkg::IOP_RST_DRIVE);
   assign ext_rst = (rst_state == iop_pkg::IOP_RST_RUN) & rst_hi_seen
                    & ~rst_lvl & ~stop_mode;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rst_state <= iop_pkg::IOP_RST_DRIVE;
         por_cnt   <= '0;
         icp_mode  <= 1'b0;
      end
      else if (clk_en)
      begin
         case (rst_state)
            iop_pkg::IOP_RST_DRIVE:
            begin
               if (por_cnt == CW'(POR_CYCLES - 1))
               begin
                  rst_state <= iop_pkg::IOP_RST_RUN;
                  por_cnt   <= '0;
                  icp_mode  <= ~prog_lvl;
               end
               else
               begin
                  por_cnt <= por_cnt + CW'(1);
               end
            end
            iop_pkg::IOP_RST_RUN:
            begin
               if (wdt_timeout)
               begin
                  rst_state <= iop_pkg::IOP_RST_DRIVE;
               end
            end
            default:
            begin
               rst_state <= iop_pkg::IOP_RST_DRIVE;
               por_cnt   <= '0;
            end
         endcase
      end
   end

   // Ignore the pin until it has been seen high after our own drive
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rst_hi_seen <= 1'b0;
      end
      else if (clk_en)
      begin
         if (driving)
         begin
            rst_hi_seen <= 1'b0;
         end
         else if (rst_lvl)
         begin
            rst_hi_seen <= 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         soft_rst_reg <= 1'b1;
         smr_rst_reg  <= 1'b0;
         device_reset <= 1'b1;
         rst_pin_out  <= 1'b0;
         rst_pin_oe   <= 1'b0;
         rst_pin_pu   <= 1'b1;
      end
      else if (clk_en)
      begin
         soft_rst_reg <= driving | low_voltage | ext_rst;
         smr_rst_reg  <= stop_recovery;
         device_reset <= driving | low_voltage | ext_rst | stop_recovery;
         rst_pin_out  <= 1'b0;
         rst_pin_oe   <= driving & ~brownout;
         rst_pin_pu   <= ~(driving & ~brownout);
      end
   end

   // ==========================================================
   // Configuration registers
   logic [7:0] p0_q, p1_q, p2_q, p3_q, p4_q;
   logic [7:0] p2_dir, p3_mode, p01_dir, pcfg, p4_dir, aux;
   logic       wr_fire;
   logic [11:0] idx;
   logic [7:0]  wd;

   assign idx     = paddr[13:2];
   assign wd      = pwdata[7:0];
   assign wr_fire = psel & penable & pwrite & pready & (paddr[1:0] == 2'h0);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         p0_q <= iop_pkg::RST_DATA;
         p1_q <= iop_pkg::RST_DATA;
         p2_q <= iop_pkg::RST_DATA;
         p3_q <= iop_pkg::RST_DATA;
         p4_q <= iop_pkg::RST_DATA;
      end
      else if (clk_en && wr_fire)
      begin
         case (idx)
            iop_pkg::IDX_P0: p0_q <= wd;
            iop_pkg::IDX_P1: p1_q <= wd;
            iop_pkg::IDX_P2: p2_q <= wd;
            iop_pkg::IDX_P3: p3_q <= wd;
            iop_pkg::IDX_P4: p4_q <= wd;
            default: p0_q <= p0_q;
         endcase
      end
   end

   // Directions to input on reset or recovery
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         p2_dir  <= iop_pkg::RST_DIR;
         p4_dir  <= iop_pkg::RST_DIR;
         p01_dir <= iop_pkg::RST_DIR;
         p3_mode <= iop_pkg::RST_P3MODE;
         aux     <= iop_pkg::RST_AUX;
      end
      else if (clk_en)
      begin
         if (soft_rst_reg || smr_rst_reg)
         begin
            p2_dir  <= iop_pkg::RST_DIR;
            p4_dir  <= iop_pkg::RST_DIR;
            p01_dir <= iop_pkg::RST_DIR;
            p3_mode <= iop_pkg::RST_P3MODE;
            aux     <= iop_pkg::RST_AUX;
         end
         else if (wr_fire)
         begin
            case (idx)
               iop_pkg::IDX_P2DIR:  p2_dir  <= wd;
               iop_pkg::IDX_P4DIR:  p4_dir  <= wd;
               iop_pkg::IDX_P01DIR: p01_dir <= wd;
               iop_pkg::IDX_P3MODE: p3_mode <= wd;
               iop_pkg::IDX_AUX:    aux     <= wd;
               default: aux <= aux;
            endcase
         end
      end
   end

   // Output config survives stop recovery
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pcfg <= iop_pkg::RST_PCFG;
      end
      else if (clk_en)
      begin
         if (soft_rst_reg)
         begin
            pcfg <= iop_pkg::RST_PCFG;
         end
         else if (wr_fire && idx == iop_pkg::IDX_PCFG)
         begin
            pcfg <= wd;
         end
      end
   end

   // ==========================================================
   // Port 3 input functions
   logic analog, iramp, p31_fn, p32_fn;
   logic p31_prev, p32_prev;
   logic [3:0] p3_prev;
   logic [7:0] p2_prev;
   logic [3:0] smr_mask;

   assign analog = p3_mode[iop_pkg::P3M_ANA];
   assign iramp  = p3_mode[iop_pkg::P3M_IRA];
   assign p31_fn = iramp ? ir_lvl : (analog ? cmp1_lvl : p3_lvl[1]);
   assign p32_fn = analog ? cmp2_lvl : p3_lvl[2];
   assign smr_mask = {1'b1, ~analog, ~(analog | iramp), 1'b1};

   function automatic logic edge_hit(input logic prev, cur, input logic [1:0] sel);
      case (sel)
         iop_pkg::EDGE_FALL: edge_hit = prev & ~cur;
         iop_pkg::EDGE_RISE: edge_hit = ~prev & cur;
         default:            edge_hit = prev ^ cur;
      endcase
   endfunction : edge_hit

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         p31_prev     <= 1'b1;
         p32_prev     <= 1'b1;
         p3_prev      <= 4'hF;
         p2_prev      <= 8'hFF;
         interrupt_request_2_req     <= 1'b0;
         interrupt_request_0_req     <= 1'b0;
         uart_rxd     <= 1'b1;
         tmr_edge_p31 <= 1'b1;
         tmr_edge_p20 <= 1'b0;
         stop_wake    <= 1'b0;
         p2_or        <= 1'b1;
         p2_and       <= 1'b1;
      end
      else if (clk_en)
      begin
         p31_prev <= p31_fn;
         p32_prev <= p32_fn;
         p3_prev  <= p3_lvl;
         p2_prev  <= p2_lvl;
         interrupt_request_2_req <= edge_hit(p31_prev, p31_fn, aux[iop_pkg::AUX_IRQ2E +: 2]);
         tmr_edge_p31 <= p31_fn;
         uart_rxd <= aux[iop_pkg::AUX_RXEN] ? p3_lvl[2] : 1'b1;
         interrupt_request_0_req <= ~aux[iop_pkg::AUX_RXEN]
                     & edge_hit(p32_prev, p32_fn, aux[iop_pkg::AUX_IRQ0E +: 2]);
         p2_or        <= |p2_lvl;
         p2_and       <= &p2_lvl;
         tmr_edge_p20 <= demod_mode & p2_lvl[0];
         stop_wake    <= stop_mode & ((|(p2_lvl ^ p2_prev))
                         | (|((p3_lvl ^ p3_prev) & smr_mask)));
      end
   end

   // ==========================================================
   // Pin drivers
   // Drive mode and pull-ups
   function automatic iop_pkg::iop_pin_s drive(input logic [7:0] val, dout, opt,
                                               input logic pp);
      drive.out = pp ? val : 8'h00;
      drive.oe  = dout & (pp ? 8'hFF : ~val);
      drive.pu  = opt & ~dout;
   endfunction : drive

   logic [7:0] p0_dout, p1_dout, p0_val;
   logic [7:0] p3_val;
   logic       p4_fn;

   assign p0_dout = {{4{~p01_dir[iop_pkg::P01_HI]}}, {4{~p01_dir[iop_pkg::P01_LO]}}};
   assign p1_dout = {8{~p01_dir[iop_pkg::P01_P1]}};
   assign p0_val  = {aux[iop_pkg::AUX_TXEN] ? uart_txd : p0_q[7], p0_q[6:0]};
   assign p4_fn   = pcfg[iop_pkg::PCFG_CMP] ? (iramp ? ir_lvl : cmp1_lvl) : p3_q[4];
   assign p3_val  = {pcfg[iop_pkg::PCFG_CMP] ? cmp2_lvl : p3_q[7],
                     aux[iop_pkg::AUX_T6] ? tmr_out[1] : p3_q[6],
                     aux[iop_pkg::AUX_T5] ? tmr_out[0] : p3_q[5],
                     p4_fn, 4'h0};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         p0_pin <= '0;
         p1_pin <= '0;
         p2_pin <= '0;
         p3_pin <= '0;
         p4_pin <= '0;
      end
      else if (clk_en)
      begin
         p0_pin <= drive(p0_val, p0_dout,
                         {{4{pullup_opt[1]}}, {4{pullup_opt[0]}}},
                         pcfg[iop_pkg::PCFG_P0PP]);
         p1_pin <= drive(p1_q, p1_dout, {8{pullup_opt[2]}},
                         pcfg[iop_pkg::PCFG_P1PP]);
         p2_pin <= drive(p2_q, ~p2_dir, {8{pullup_opt[3]}},
                         p3_mode[iop_pkg::P3M_P2PP]);
         p4_pin <= drive(p4_q, ~p4_dir, {8{pullup_opt[4]}},
                         pcfg[iop_pkg::PCFG_P4PP]);
         // Port 3 outputs and programming pin
         p3_pin.out <= p3_val;
         p3_pin.oe  <= {3'h7, driving ? 1'b0 : (icp_mode ? ~p4_fn : 1'b1), 4'h0};
         p3_pin.pu  <= {3'h0, driving, 4'h0};
      end
   end

   // ==========================================================
   // APB read path
   logic [7:0] rd_val;
   logic       rd_hit;

   always_comb
   begin
      rd_hit = (paddr[1:0] == 2'h0);
      case (idx)
         iop_pkg::IDX_P0:     rd_val = p0_lvl;
         iop_pkg::IDX_P1:     rd_val = p1_lvl;
         iop_pkg::IDX_P2:     rd_val = p2_lvl;
         iop_pkg::IDX_P3:     rd_val = {p3_q[7:5], icp_mode ? prog_lvl : p3_q[4],
                                        p3_lvl[3:1], analog | p3_lvl[0]};
         iop_pkg::IDX_P4:     rd_val = p4_lvl;
         iop_pkg::IDX_P2DIR:  rd_val = p2_dir;
         iop_pkg::IDX_P3MODE: rd_val = p3_mode;
         iop_pkg::IDX_P01DIR: rd_val = p01_dir;
         iop_pkg::IDX_PCFG:   rd_val = iop_pkg::PCFG_RD1 | (pcfg & iop_pkg::PCFG_KEEP);
         iop_pkg::IDX_P4DIR:  rd_val = p4_dir;
         iop_pkg::IDX_AUX:    rd_val = aux;
         iop_pkg::IDX_STAT:   rd_val = {4'h0, p2_and, p2_or, stop_wake, icp_mode};
         default:
         begin
            rd_val = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (clk_en)
      begin
         pready  <= psel & penable & ~pready;
         prdata  <= {24'h00_0000, rd_hit ? rd_val : 8'h00};
         pslverr <= psel & penable & ~pready & ~rd_hit;
      end
   end
endmodule : iop_ports

// File: iop_pkg.sv
// Purpose: Shared constants and types for the I/O port block
// Assumes: Register index times four gives the APB byte address
// Notes:   Offsets below are register indices, not byte addresses
package iop_pkg;
   // ==========================================================
   // Timing
   localparam int unsigned CLK_MHZ     = 125;
   localparam int unsigned POR_TIME_NS = 1000;
   localparam int unsigned POR_CYC     = (POR_TIME_NS * CLK_MHZ + 999) / 1000;

   // ==========================================================
   // Register indices
   localparam logic [11:0] IDX_P0     = 12'h000;
   localparam logic [11:0] IDX_P1     = 12'h001;
   localparam logic [11:0] IDX_P2     = 12'h002;
   localparam logic [11:0] IDX_P3     = 12'h003;
   localparam logic [11:0] IDX_P2DIR  = 12'h0F6;
   localparam logic [11:0] IDX_P3MODE = 12'h0F7;
   localparam logic [11:0] IDX_P01DIR = 12'h0F8;
   localparam logic [11:0] IDX_PCFG   = 12'hF00;
   localparam logic [11:0] IDX_P4     = 12'hF08;
   localparam logic [11:0] IDX_P4DIR  = 12'hF09;
   localparam logic [11:0] IDX_AUX    = 12'h100;
   localparam logic [11:0] IDX_STAT   = 12'h101;

   // ==========================================================
   // Reset values and read masks
   localparam logic [7:0] RST_DATA   = 8'h00;
   localparam logic [7:0] RST_DIR    = 8'hFF;
   localparam logic [7:0] RST_P3MODE = 8'h00;
   localparam logic [7:0] RST_PCFG   = 8'h0E;
   localparam logic [7:0] RST_AUX    = 8'h00;
   localparam logic [7:0] PCFG_RD1   = 8'hF7;
   localparam logic [7:0] PCFG_KEEP  = 8'h08;

   // ==========================================================
   // Field positions
   localparam int P01_HI    = 6;
   localparam int P01_P1    = 3;
   localparam int P01_LO    = 0;
   localparam int PCFG_P4PP = 3;
   localparam int PCFG_P0PP = 2;
   localparam int PCFG_P1PP = 1;
   localparam int PCFG_CMP  = 0;
   localparam int P3M_P2PP  = 0;
   localparam int P3M_ANA   = 1;
   localparam int P3M_IRA   = 2;
   localparam int AUX_TXEN  = 0;
   localparam int AUX_RXEN  = 1;
   localparam int AUX_T5    = 2;
   localparam int AUX_T6    = 3;
   localparam int AUX_IRQ2E = 4;
   localparam int AUX_IRQ0E = 6;

   // Edge select codes
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      IOP_RST_DRIVE = 2'b01,
      IOP_RST_RUN   = 2'b10
   } iop_rst_e;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] pu;
   } iop_pin_s;
endpackage : iop_pkg

// File: iop_pin_model.sv
// Purpose: Outside circuits on one port and on the reset line
// Assumes: Outside drivers only pull low
// Notes:   A floating line with no pull-up reads low
`timescale 1ns/100ps
module iop_pin_model (
   // Device side
   input  wire iop_pkg::iop_pin_s pin,
   // Outside pull-down and level seen
   input  wire logic [7:0]        ext_low,
   output logic      [7:0]        level
);
   assign level = ~ext_low & ((pin.oe & pin.out) | (~pin.oe & pin.pu));
endmodule : iop_pin_model

// File: iop_sva.sv
// Purpose: Port-level checks of the I/O port block
// Assumes: One clock domain
// Notes:   Bound to every iop_ports instance
`timescale 1ns/100ps
module iop_sva (
   // Clock and bus
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              clk_en,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pready,
   input wire logic              pslverr,
   // Pins
   input wire iop_pkg::iop_pin_s p0_pin,
   input wire iop_pkg::iop_pin_s p1_pin,
   input wire iop_pkg::iop_pin_s p2_pin,
   input wire iop_pkg::iop_pin_s p3_pin,
   input wire iop_pkg::iop_pin_s p4_pin,
   input wire logic              rst_pin_out,
   input wire logic              rst_pin_oe,
   input wire logic              rst_pin_pu,
   // Status
   input wire logic              brownout,
   input wire logic              device_reset,
   input wire logic              icp_mode,
   input wire logic              interrupt_request_2_req
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_wait; psel && penable && !pready && clk_en; endsequence
   sequence s_run; !device_reset [*3]; endsequence
   sequence s_held; device_reset [*3]; endsequence
   // ==========================================================
   // Checks
   pready_wait_a: assert property (s_wait |=> pready) else $error("pready late");
   err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
   rst_drive_a: assert property (rst_pin_oe |-> !rst_pin_pu && !rst_pin_out)
      else $error("reset pin drive wrong");
   brownout_quiet_a: assert property (brownout [*2] |-> !rst_pin_oe)
      else $error("reset pin driven in brownout");
   pullup_off_a: assert property (((p0_pin.pu & p0_pin.oe) | (p1_pin.pu & p1_pin.oe)
      | (p2_pin.pu & p2_pin.oe) | (p4_pin.pu & p4_pin.oe)) == 8'h00) else $error("pull-up on");
   p3_nibble_a: assert property ({p3_pin.oe[3:0], p3_pin.out[3:0]} == 8'h00)
      else $error("port3 low nibble driven");
   p3_push_a: assert property (s_run |-> p3_pin.oe[7:5] == 3'h7)
      else $error("port3 outputs not driven");
   reset_input_a: assert property (s_held |-> (p0_pin.oe | p1_pin.oe | p2_pin.oe | p4_pin.oe)
      == 8'h00) else $error("port driven in reset");
   icp_hold_a: assert property (s_run |-> $stable(icp_mode))
      else $error("icp mode moved");
   irq_pulse_a: assert property (interrupt_request_2_req |=> !interrupt_request_2_req) else $error("interrupt_request_2 too long");
endmodule : iop_sva

bind iop_ports iop_sva u_sva (.pclk, .presetn, .clk_en, .psel, .penable, .pready, .pslverr,
   .p0_pin, .p1_pin, .p2_pin, .p3_pin, .p4_pin, .rst_pin_out, .rst_pin_oe, .rst_pin_pu,
   .brownout, .device_reset, .icp_mode, .interrupt_request_2_req);

// File: testbench.sv
// Purpose: Self-checking bench for the I/O port block
// Assumes: Byte address is four times the register index
// Notes:   Short reset drive count keeps the run brief
`timescale 1ns/100ps
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, seen;
   logic prog_pin_in, rst_pin_in, rst_pin_out, rst_pin_oe, rst_pin_pu, wdt_timeout, brownout;
   logic uart_txd, cmp1_out, cmp2_out, ir_amp_out, device_reset, icp_mode, interrupt_request_2_req;
   logic clk_en, low_voltage, stop_recovery, stop_mode, demod_mode;
   logic [13:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0]  p0_in, p1_in, p2_in, p4_in, ext, rd, v, rlev;
   logic [4:0]  pullup_opt;
   logic [3:0]  p3_in;
   logic [1:0]  tmr_out;
   iop_pkg::iop_pin_s p0_pin, p1_pin, p2_pin, p3_pin, p4_pin;
   int seed, miscompares, compares, n;
   iop_ports #(.POR_CYCLES(6)) uut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .p0_in, .p1_in, .p2_in, .p3_in, .p4_in,
      .prog_pin_in, .p0_pin, .p1_pin, .p2_pin, .p3_pin, .p4_pin, .rst_pin_in, .rst_pin_out,
      .rst_pin_oe, .rst_pin_pu, .wdt_timeout, .low_voltage, .stop_recovery,
      .stop_mode, .brownout, .demod_mode, .pullup_opt, .uart_txd, .tmr_out,
      .cmp1_out, .cmp2_out, .ir_amp_out, .device_reset, .icp_mode, .interrupt_request_2_req, .interrupt_request_0_req(),
      .uart_rxd(), .tmr_edge_p31(), .tmr_edge_p20(), .stop_wake(), .p2_or(), .p2_and());
   iop_pin_model m0 (.pin(p0_pin), .ext_low(8'h00), .level(p0_in));
   iop_pin_model m1 (.pin(p1_pin), .ext_low(8'h00), .level(p1_in));
   iop_pin_model m2 (.pin(p2_pin), .ext_low(ext), .level(p2_in));
   iop_pin_model m4 (.pin(p4_pin), .ext_low(8'h00), .level(p4_in));
   iop_pin_model mr (.pin({7'h0, rst_pin_out, 7'h0, rst_pin_oe, 7'h0, rst_pin_pu}),
      .ext_low(8'h00), .level(rlev));
   assign rst_pin_in = rlev[0];

   function logic [7:0] gates(input logic [7:0] x);
      return {4'h0, &x, |x, 2'h0};
   endfunction : gates

   task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task apb(input logic [11:0] idx, input logic wr, input logic [7:0] wd);
      @(posedge pclk);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= wr;
      paddr   <= {idx, 2'h0};
      pwdata  <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'h1 && n < 20);
      if (n >= 20) miscompares++;
      rd  = prdata[7:0];
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   task settle;
      repeat (3) @(posedge pclk);
      for (int i = 0; i < 100 && device_reset !== 1'h0; i++) @(posedge pclk);
      repeat (3) @(posedge pclk);
   endtask : settle

   task wdog(input logic bo);
      brownout    <= bo;
      wdt_timeout <= 1'h1;
      @(posedge pclk);
      wdt_timeout <= 1'h0;
      repeat (3) @(posedge pclk);
   endtask : wdog

   task wrap_up;
      $display("Counts: %0d compares, %0d miscompares", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : wrap_up

   initial
   begin
      pclk = 1'h0;
      forever #4 pclk = ~pclk;
   end

   initial
   begin
      #200000;
      miscompares++;
      wrap_up;
   end

   initial
   begin
      seed = 82;
      {miscompares, compares, presetn, psel, penable, pwrite, paddr, pwdata, ext} = '0;
      {clk_en, p3_in, pullup_opt, prog_pin_in} = 11'h7FF;
      {wdt_timeout, brownout, uart_txd, low_voltage, stop_recovery, stop_mode, demod_mode} = 7'h0;
      {tmr_out, cmp1_out, cmp2_out, ir_amp_out} = 5'($random(seed));
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      settle;
      apb(iop_pkg::IDX_P2DIR, 0, 0); chk("p2 dir", iop_pkg::RST_DIR, rd);
      apb(iop_pkg::IDX_P4DIR, 0, 0); chk("p4 dir", iop_pkg::RST_DIR, rd);
      apb(iop_pkg::IDX_P01DIR, 0, 0); chk("p01 dir", 8'hFF, rd);
      apb(iop_pkg::IDX_PCFG, 0, 0); chk("pcfg", 8'hFF, rd);
      apb(12'h050, 0, 0); chk("unmapped", 8'h01, {7'h0, err});
      $display("Test registers done");
      v = 8'($random(seed));
      apb(iop_pkg::IDX_P3MODE, 1, 8'h01);
      apb(iop_pkg::IDX_P2, 1, v); chk("p2 oe", 8'h00, p2_pin.oe);
      apb(iop_pkg::IDX_P2DIR, 1, 8'h00);
      repeat (6) @(posedge pclk);
      chk("p2 out", v, p2_pin.out);
      chk("p2 pull", 8'h00, p2_pin.pu);
      apb(iop_pkg::IDX_P2, 0, 0); chk("p2 read", v, rd);
      apb(iop_pkg::IDX_P3MODE, 1, 8'h00);
      repeat (6) @(posedge pclk);
      apb(iop_pkg::IDX_P2, 0, 0); chk("p2 od read", 8'h00, rd);
      $display("Test port 2 done");
      apb(iop_pkg::IDX_P2DIR, 1, 8'hFF);
      for (int i = 0; i < 6; i++)
      begin
         ext <= (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
         repeat (6) @(posedge pclk);
         apb(iop_pkg::IDX_STAT, 0, 0); chk("p2 gates", gates(~ext), rd & 8'h0C);
      end
      apb(iop_pkg::IDX_P01DIR, 1, 8'hBF);
      apb(iop_pkg::IDX_AUX, 1, 8'h01);
      for (int i = 0; i < 4; i++)
      begin
         uart_txd <= 1'($random(seed));
         repeat (3) @(posedge pclk);
         chk("tx pin", {7'h0, uart_txd}, {7'h0, p0_pin.out[7]});
         chk("tx drive", 8'h80, p0_pin.oe & 8'h80);
      end
      $display("Test gates and tx done");
      p3_in <= 4'h0;
      for (int m = 1; m >= 0; m--)
      begin
         apb(iop_pkg::IDX_P3MODE, 1, m[0] ? 8'h02 : 8'h00);
         repeat (6) @(posedge pclk);
         apb(iop_pkg::IDX_P3, 0, 0); chk("p3 bit0", {7'h0, m[0]}, rd & 8'h01);
      end
      apb(iop_pkg::IDX_AUX, 1, 8'h10);
      for (int e = 1; e >= 0; e--)
      begin
         p3_in <= {2'h0, e[0], 1'h0};
         seen = 1'h0;
         repeat (10) @(posedge pclk) seen |= interrupt_request_2_req;
         chk("interrupt_request_2", {7'h0, e[0]}, {7'h0, seen});
      end
      $display("Test port 3 done");
      apb(iop_pkg::IDX_P4DIR, 1, 8'h0F);
      prog_pin_in <= 1'h0;
      wdog(1'h0);
      chk("reset drive", 8'h01, {7'h0, rst_pin_oe});
      settle;
      chk("icp mode", 8'h01, {7'h0, icp_mode});
      apb(iop_pkg::IDX_P4DIR, 0, 0); chk("p4 dir again", 8'hFF, rd);
      wdog(1'h1);
      chk("brownout drive", 8'h00, {7'h0, rst_pin_oe});
      settle;
      brownout <= 1'h0;
      apb(iop_pkg::IDX_P4DIR, 1, 8'h0F);
      low_voltage <= 1'h1;
      repeat (3) @(posedge pclk);
      low_voltage <= 1'h0;
      apb(iop_pkg::IDX_P4DIR, 0, 0); chk("lv reset", 8'hFF, rd);
      $display("Test reset pin done");
      wrap_up;
   end
endmodule : testbench
